// ===== shared/mcast_fwd_pkg.sv
package mcast_fwd_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] TBL_IDX_OFFSET = 8'h08;
  localparam logic [7:0] TBL_CTRL_OFFSET = 8'h0c;
  localparam logic [7:0] TBL_DATA_OFFSET = 8'h10;
  // control fields
  localparam int CTRL_GLOBAL_DIS_BIT = 0;
  localparam int CTRL_POLICY_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // table control / data fields
  localparam int TBL_FORCE_DIS_BIT = 0;
  localparam int TBL_MODE_LSB = 0;
  localparam int TBL_MRX_BIT = 2;
  localparam int TBL_DONE_BIT = 3;
  localparam int TBL_IGMP_LSB = 4;
  localparam int TBL_MLD_LSB = 6;
  localparam int TBL_PRIM_LSB = 8;
  // status fields
  localparam int STATUS_GRANT_LSB = 0;
  localparam int STATUS_COUNT_LSB = 8;
  // granted label_based_multicast_forwarding capability values
  localparam logic [1:0] CAP_DISABLED = 2'h0;
  localparam logic [1:0] CAP_EXPLICIT = 2'h1;
  localparam logic [1:0] CAP_PROMISC = 2'h2;
  // frame_control_type of a packet PDU header
  localparam logic [1:0] FRAME_CONTROL_TYPE_PACKET = 2'h0;
  // downstream_extended_header lengths in bytes
  localparam logic [2:0] EHDR_NONE = 3'h0;
  localparam logic [2:0] EHDR_1B = 3'h1;
  localparam logic [2:0] EHDR_3B = 3'h3;
  localparam logic [2:0] EHDR_5B = 3'h5;
  // group-management versions
  localparam logic [1:0] IGMP_V2 = 2'h2;
  localparam logic [1:0] IGMP_V3 = 2'h3;
  localparam logic [1:0] MLD_NONE = 2'h0;
  localparam logic [1:0] MLD_V2 = 2'h2;
  // header policy for copies toward disabled modems
  typedef enum logic [1:0] {
    POL_NONE = 2'b00,
    POL_1B = 2'b01,
    POL_3B = 2'b10,
    POL_5B = 2'b11
  } ehdr_policy_e;
endpackage : mcast_fwd_pkg

// ===== rtl/mcast_fwd.sv
`timescale 1ns/1ps
module mcast_fwd
  import mcast_fwd_pkg::*;
#(
  parameter int NUM_MODEMS = 16,
  parameter int CH_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic reg_valid_i,
  input wire logic [$clog2(NUM_MODEMS)-1:0] reg_modem_i,
  input wire logic reg_cap_present_i,
  input wire logic [1:0] reg_cap_i,
  input wire logic [CH_W-1:0] reg_primary_ch_i,
  input wire logic reg_multi_rx_i,
  output logic rsp_valid_o,
  output logic [1:0] rsp_cap_o,
  input wire logic rep_valid_i,
  input wire logic [$clog2(NUM_MODEMS)-1:0] rep_modem_i,
  input wire logic rep_prereg_i,
  input wire logic [CH_W-1:0] rep_ch_i,
  input wire logic rep_bonded_i,
  output logic rep_valid_o,
  output logic [CH_W-1:0] rep_ch_o,
  output logic rep_bonded_o,
  output logic [1:0] rep_frame_control_type_o,
  output logic [2:0] rep_ehdr_len_o,
  output logic rep_label_en_o,
  input wire logic sig_valid_i,
  input wire logic [$clog2(NUM_MODEMS)-1:0] sig_modem_i,
  input wire logic sig_mcast_i,
  input wire logic sig_reseq_i,
  input wire logic sig_isolating_sa_i,
  output logic sig_valid_o,
  output logic sig_mcast_enc_o,
  output logic sig_reseq_o,
  output logic sig_sa_ok_o
);
  localparam int IDW = $clog2(NUM_MODEMS);

  initial begin
    if (NUM_MODEMS < 2 || NUM_MODEMS > 256 || CH_W < 1 || CH_W > 16) begin
      $error("mcast_fwd: unsupported parameters");
    end
  end

  function automatic logic is_disabled(input logic [1:0] mode, input logic done);
    is_disabled = (mode == CAP_DISABLED) || !done;
  endfunction : is_disabled

  //////////////////////////////////////////////////////////////////////////////
  // per-modem state, then global registers and decodes
  logic [1:0] mode_mem [NUM_MODEMS];
  logic [CH_W-1:0] prim_mem [NUM_MODEMS];
  logic [NUM_MODEMS-1:0] mrx_reg;
  logic [NUM_MODEMS-1:0] done_reg;
  logic [NUM_MODEMS-1:0] force_dis_reg;
  logic [31:0] ctrl_reg;
  logic [IDW-1:0] tbl_idx_reg;
  logic [7:0] reg_count_reg;
  logic [1:0] last_grant_reg;
  logic global_dis;
  ehdr_policy_e policy;
  logic [1:0] grant;
  logic rep_dis;
  logic sig_dis;
  logic wb_req;
  logic wb_wr;

  assign global_dis = ctrl_reg[CTRL_GLOBAL_DIS_BIT];
  assign policy = ehdr_policy_e'(ctrl_reg[CTRL_POLICY_LSB +: 2]);
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land on the edge where the master samples ack, so both sides agree on when
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign rep_dis = is_disabled(mode_mem[rep_modem_i], done_reg[rep_modem_i]);
  assign sig_dis = is_disabled(mode_mem[sig_modem_i], done_reg[sig_modem_i]);

  // granted capability: forced zero by software, zero for absent or zero reports
  always_comb begin
    if (!reg_cap_present_i || reg_cap_i == CAP_DISABLED) begin
      grant = CAP_DISABLED;
    end else if (global_dis || force_dis_reg[reg_modem_i]) begin
      grant = CAP_DISABLED;
    end else if (reg_cap_i == CAP_PROMISC) begin
      grant = CAP_PROMISC;
    end else begin
      grant = CAP_EXPLICIT; // reserved code 3 falls back to explicit
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registration: record the mode flag and answer with the grant
  // cleared on reset so an unregistered modem reads back disabled on channel zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int m = 0; m < NUM_MODEMS; m++) begin
        mode_mem[m] <= CAP_DISABLED;
        prim_mem[m] <= '0;
      end
    end else if (reg_valid_i) begin
      mode_mem[reg_modem_i] <= grant;
      prim_mem[reg_modem_i] <= reg_primary_ch_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_reg <= '0;
      mrx_reg <= '0;
      rsp_valid_o <= 1'b0;
      rsp_cap_o <= CAP_DISABLED;
      last_grant_reg <= CAP_DISABLED;
      reg_count_reg <= 8'h00;
    end else begin
      rsp_valid_o <= reg_valid_i;
      if (reg_valid_i) begin
        done_reg[reg_modem_i] <= 1'b1;
        mrx_reg[reg_modem_i] <= reg_multi_rx_i;
        rsp_cap_o <= grant;
        last_grant_reg <= grant;
        if (reg_count_reg != 8'hff) begin
          reg_count_reg <= reg_count_reg + 8'h01; // saturates so it never wraps
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // replication decision, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rep_valid_o <= 1'b0;
      rep_ch_o <= '0;
      rep_bonded_o <= 1'b0;
      rep_frame_control_type_o <= FRAME_CONTROL_TYPE_PACKET;
      rep_ehdr_len_o <= EHDR_NONE;
      rep_label_en_o <= 1'b0;
    end else begin
      rep_valid_o <= rep_valid_i;
      if (rep_valid_i) begin
        rep_frame_control_type_o <= FRAME_CONTROL_TYPE_PACKET;
        if (rep_prereg_i) begin
          rep_ch_o <= rep_ch_i;
          rep_bonded_o <= 1'b0;
          rep_ehdr_len_o <= global_dis ? EHDR_NONE : EHDR_3B;
          rep_label_en_o <= !global_dis;
        end else if (rep_dis) begin
          rep_ch_o <= prim_mem[rep_modem_i];
          rep_bonded_o <= 1'b0;
          case (policy)
            POL_NONE: rep_ehdr_len_o <= EHDR_NONE;
            POL_1B: rep_ehdr_len_o <= EHDR_1B;
            POL_3B: rep_ehdr_len_o <= EHDR_3B;
            POL_5B: rep_ehdr_len_o <= EHDR_5B;
            default: rep_ehdr_len_o <= EHDR_NONE;
          endcase
          // the modem ignores a 3-byte label it never learnt, so one copy can serve all
          rep_label_en_o <= (policy == POL_3B) || (policy == POL_5B);
        end else begin
          rep_ch_o <= rep_ch_i;
          rep_bonded_o <= rep_bonded_i;
          rep_ehdr_len_o <= EHDR_3B;
          rep_label_en_o <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // label signalling filter toward one modem
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sig_valid_o <= 1'b0;
      sig_mcast_enc_o <= 1'b0;
      sig_reseq_o <= 1'b0;
      sig_sa_ok_o <= 1'b0;
    end else begin
      sig_valid_o <= sig_valid_i;
      if (sig_valid_i) begin
        sig_mcast_enc_o <= sig_mcast_i && !sig_dis;
        sig_reseq_o <= sig_reseq_i || (sig_dis && mrx_reg[sig_modem_i] && policy == POL_5B);
        sig_sa_ok_o <= !(sig_dis && sig_isolating_sa_i);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one-cycle ack, unmapped reads return zero, writes ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          CTRL_OFFSET: wb_dat_o <= ctrl_reg;
          STATUS_OFFSET: begin
            wb_dat_o[STATUS_GRANT_LSB +: 2] <= last_grant_reg;
            wb_dat_o[STATUS_COUNT_LSB +: 8] <= reg_count_reg;
          end
          TBL_IDX_OFFSET: wb_dat_o[IDW-1:0] <= tbl_idx_reg;
          TBL_CTRL_OFFSET: wb_dat_o[TBL_FORCE_DIS_BIT] <= force_dis_reg[tbl_idx_reg];
          TBL_DATA_OFFSET: begin
            wb_dat_o[TBL_MODE_LSB +: 2] <= mode_mem[tbl_idx_reg];
            wb_dat_o[TBL_MRX_BIT] <= mrx_reg[tbl_idx_reg];
            wb_dat_o[TBL_DONE_BIT] <= done_reg[tbl_idx_reg];
            // version reporting follows the stored mode flag
            if (is_disabled(mode_mem[tbl_idx_reg], done_reg[tbl_idx_reg])) begin
              wb_dat_o[TBL_IGMP_LSB +: 2] <= IGMP_V2;
              wb_dat_o[TBL_MLD_LSB +: 2] <= MLD_NONE;
            end else begin
              wb_dat_o[TBL_IGMP_LSB +: 2] <= IGMP_V3;
              wb_dat_o[TBL_MLD_LSB +: 2] <= MLD_V2;
            end
            wb_dat_o[TBL_PRIM_LSB +: CH_W] <= prim_mem[tbl_idx_reg];
          end
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // register writes honour byte lanes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RESET;
      tbl_idx_reg <= '0;
      force_dis_reg <= '0;
    end else if (wb_wr) begin
      if (wb_adr_i == CTRL_OFFSET) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            ctrl_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
          end
        end
      end
      if (wb_adr_i == TBL_IDX_OFFSET && wb_sel_i[0]) begin
        tbl_idx_reg <= wb_dat_i[IDW-1:0];
      end
      if (wb_adr_i == TBL_CTRL_OFFSET && wb_sel_i[0]) begin
        force_dis_reg[tbl_idx_reg] <= wb_dat_i[TBL_FORCE_DIS_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_grant_absent_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_valid_i && !reg_cap_present_i |=> rsp_valid_o && rsp_cap_o == CAP_DISABLED)
    else $error("absent capability not granted zero");

  a_force_dis_grant: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_valid_i && force_dis_reg[reg_modem_i] |=> rsp_cap_o == CAP_DISABLED)
    else $error("forced disable not honoured");

  a_dis_primary_ch: assert property (@(posedge clk_i) disable iff (rst_i)
    rep_valid_i && !rep_prereg_i && rep_dis |=> rep_ch_o == $past(prim_mem[rep_modem_i]) && !rep_bonded_o)
    else $error("disabled copy not on primary channel");

  a_fc_packet_type: assert property (@(posedge clk_i) disable iff (rst_i)
    rep_valid_o |-> rep_frame_control_type_o == FRAME_CONTROL_TYPE_PACKET)
    else $error("copy not packet header type");

  a_prereg_nolabel: assert property (@(posedge clk_i) disable iff (rst_i)
    rep_valid_i && rep_prereg_i && global_dis |=> !rep_label_en_o && rep_ehdr_len_o == EHDR_NONE)
    else $error("pre-registration copy labelled");

  a_no_mcast_label: assert property (@(posedge clk_i) disable iff (rst_i)
    sig_valid_i && sig_dis ##1 sig_valid_o |-> !sig_mcast_enc_o)
    else $error("multicast label signalled to disabled modem");

  a_no_isolating_sa: assert property (@(posedge clk_i) disable iff (rst_i)
    sig_valid_i && sig_dis && sig_isolating_sa_i |=> !sig_sa_ok_o)
    else $error("isolating association granted");

  a_reseq_5byte: assert property (@(posedge clk_i) disable iff (rst_i)
    sig_valid_i && sig_dis && mrx_reg[sig_modem_i] && policy == POL_5B |=> sig_reseq_o)
    else $error("5-byte label not signalled as resequencing");

  a_wb_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule : mcast_fwd

// ===== verification/modem_rx_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// receive side of a forwarding-disabled modem fed by the head-end copies
module modem_rx_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rep_valid_i,
  input wire logic [2:0] rep_ehdr_len_i,
  input wire logic [7:0] up_i,
  output logic [7:0] up_o,
  output logic [15:0] host_cnt_o
);
  // upstream multicast goes out untouched; no join proxy sits in this path
  assign up_o = up_i;
  // every copy reaches the host stack, labelled or not; a 3-byte header is
  // skipped rather than used as a filter, so no provisioning group is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_cnt_o <= 16'h0;
    end else if (rep_valid_i && rep_ehdr_len_i <= 3'h5) begin
      host_cnt_o <= host_cnt_o + 16'h1;
    end
  end
endmodule : modem_rx_model

// ===== verification/multicast_mode0_forwarding_test.sv
`timescale 1ns/1ps
module multicast_mode0_forwarding_test;
  import mcast_fwd_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rnd, q;
  logic [3:0] reg_modem_i, rep_modem_i, sig_modem_i;
  logic reg_valid_i, reg_cap_present_i, reg_multi_rx_i, rsp_valid_o, rep_valid_i, rep_prereg_i, rep_bonded_i;
  logic [1:0] reg_cap_i, rsp_cap_o, rep_frame_control_type_o;
  logic [7:0] reg_primary_ch_i, rep_ch_i, rep_ch_o;
  logic rep_valid_o, rep_bonded_o, rep_label_en_o, sig_valid_i, sig_mcast_i, sig_reseq_i, sig_isolating_sa_i;
  logic [2:0] rep_ehdr_len_o;
  logic sig_valid_o, sig_mcast_enc_o, sig_reseq_o, sig_sa_ok_o;
  logic [15:0] host_cnt;
  int mismatches, tests_run, cyc, pol, gdis, nreg, lastg, nrep, k, i;
  int gr[16], prim[16], mrx[16], frc[16], regd[16];
  mcast_fwd mcast_fwd_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'hf), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .reg_valid_i(reg_valid_i), .reg_modem_i(reg_modem_i),
    .reg_cap_present_i(reg_cap_present_i), .reg_cap_i(reg_cap_i), .reg_primary_ch_i(reg_primary_ch_i),
    .reg_multi_rx_i(reg_multi_rx_i), .rsp_valid_o(rsp_valid_o), .rsp_cap_o(rsp_cap_o),
    .rep_valid_i(rep_valid_i), .rep_modem_i(rep_modem_i), .rep_prereg_i(rep_prereg_i), .rep_ch_i(rep_ch_i),
    .rep_bonded_i(rep_bonded_i), .rep_valid_o(rep_valid_o), .rep_ch_o(rep_ch_o), .rep_bonded_o(rep_bonded_o),
    .rep_frame_control_type_o(rep_frame_control_type_o), .rep_ehdr_len_o(rep_ehdr_len_o), .rep_label_en_o(rep_label_en_o),
    .sig_valid_i(sig_valid_i), .sig_modem_i(sig_modem_i), .sig_mcast_i(sig_mcast_i), .sig_reseq_i(sig_reseq_i),
    .sig_isolating_sa_i(sig_isolating_sa_i), .sig_valid_o(sig_valid_o), .sig_mcast_enc_o(sig_mcast_enc_o),
    .sig_reseq_o(sig_reseq_o), .sig_sa_ok_o(sig_sa_ok_o));
  modem_rx_model modem_rx_model_i (.clk_i(clk_i), .rst_i(rst_i), .rep_valid_i(rep_valid_o),
    .rep_ehdr_len_i(rep_ehdr_len_o), .up_i(rnd[7:0]), .up_o(), .host_cnt_o(host_cnt));
  ////////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
  endfunction : lfsr
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic end_sim();
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////////
  // classic wishbone cycle; waits for ack however long it takes
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  // registration: granted value follows report, global and per-modem disable
  task automatic do_reg(input logic [3:0] m, input logic p, input logic [1:0] c);
    lastg = (!p || c == 2'h0 || gdis || frc[m]) ? 0 : (c == 2'h2) ? 2 : 1;
    @(posedge clk_i);
    reg_valid_i <= 1'b1;
    reg_modem_i <= m;
    reg_cap_present_i <= p;
    reg_cap_i <= c;
    reg_primary_ch_i <= rnd[15:8];
    reg_multi_rx_i <= rnd[16];
    {gr[m], prim[m], mrx[m], regd[m]} = {lastg, int'(rnd[15:8]), int'(rnd[16]), 32'd1};
    nreg++;
    @(posedge clk_i);
    reg_valid_i <= 1'b0;
    @(posedge clk_i);
    check("rsp_valid", rsp_valid_o, 1);
    check("rsp_cap", rsp_cap_o, lastg);
  endtask : do_reg
  // one copy: channel, bonding and header length per mode, frame type for disabled-modem copies only
  task automatic do_rep(input logic [3:0] m, input logic pre);
    logic dis;
    logic [31:0] ech, eb, ee, el;
    dis = !regd[m] || gr[m] == 0;
    {ech, eb, ee, el} = {32'(rnd[15:8]), 32'(rnd[16]), 32'h3, 32'h1};
    if (pre) {eb, ee, el} = {32'h0, gdis ? 32'h0 : 32'h3, 32'(!gdis)};
    else if (dis) {ech, eb, ee, el} = {32'(prim[m]), 32'h0, pol == 0 ? 32'h0 : 32'(2 * pol - 1), 32'(pol >= 2)};
    @(posedge clk_i);
    rep_valid_i <= 1'b1;
    rep_modem_i <= m;
    rep_prereg_i <= pre;
    rep_ch_i <= rnd[15:8];
    rep_bonded_i <= rnd[16];
    nrep++;
    @(posedge clk_i);
    rep_valid_i <= 1'b0;
    @(posedge clk_i);
    check("rep_valid", rep_valid_o, 1);
    check("rep_ch", rep_ch_o, ech);
    check("rep_bonded", rep_bonded_o, eb);
    check("rep_ehdr", rep_ehdr_len_o, ee);
    check("rep_label", rep_label_en_o, el);
    if (!pre && dis) check("rep_fc", rep_frame_control_type_o, FRAME_CONTROL_TYPE_PACKET);
  endtask : do_rep
  // label signalling toward a modem
  task automatic do_sig(input logic [3:0] m);
    logic dis;
    dis = !regd[m] || gr[m] == 0;
    @(posedge clk_i);
    sig_valid_i <= 1'b1;
    sig_modem_i <= m;
    {sig_mcast_i, sig_reseq_i, sig_isolating_sa_i} <= rnd[18:16];
    @(posedge clk_i);
    sig_valid_i <= 1'b0;
    @(posedge clk_i);
    check("sig_valid", sig_valid_o, 1);
    check("sig_mcast", sig_mcast_enc_o, rnd[18] & !dis);
    check("sig_reseq", sig_reseq_o, rnd[17] | (dis & mrx[m] & pol == 3));
    check("sig_sa", sig_sa_ok_o, !(dis & rnd[16]));
  endtask : do_sig
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rnd = 32'h8b6171c9;
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {1'b1, 43'h0};
    {reg_valid_i, reg_modem_i, reg_cap_present_i, reg_cap_i, reg_primary_ch_i, reg_multi_rx_i} = 17'h0;
    {rep_valid_i, rep_modem_i, rep_prereg_i, rep_ch_i, rep_bonded_i} = 15'h0;
    {sig_valid_i, sig_modem_i, sig_mcast_i, sig_reseq_i, sig_isolating_sa_i} = 8'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CTRL_OFFSET, 32'h0);
    check("ctrl_rst", q, CTRL_RESET);
    wb(1'b0, STATUS_OFFSET, 32'h0);
    check("status_rst", q, 32'h0);
    // unmapped place: write is dropped, read returns zero
    wb(1'b1, 8'h40, 32'hffff_ffff);
    wb(1'b0, 8'h40, 32'h0);
    check("unmapped", q, 32'h0);
    // modem 3 is forced off whatever it reports
    wb(1'b1, TBL_IDX_OFFSET, 32'h3);
    wb(1'b1, TBL_CTRL_OFFSET, 32'h1);
    frc[3] = 1;
    do_reg(4'h3, 1'b1, 2'h1);
    // each header policy, then global disable on top of policy POL_NONE
    for (k = 0; k < 5; k++) begin
      {pol, gdis} = {k % 4, int'(k == 4)};
      wb(1'b1, CTRL_OFFSET, 32'((pol << 4) | gdis));
      for (i = 0; i < 8; i++) begin
        rnd = lfsr(rnd);
        do_reg(rnd[3:0], rnd[4], rnd[6:5]);
        rnd = lfsr(rnd);
        do_rep(rnd[3:0], rnd[4] & rnd[5]);
        rnd = lfsr(rnd);
        do_sig(rnd[3:0]);
      end
    end
    // per-modem table: mode, group-management versions, primary channel
    for (i = 0; i < 16; i++) begin
      if (regd[i]) begin
        wb(1'b1, TBL_IDX_OFFSET, 32'(i));
        wb(1'b0, TBL_DATA_OFFSET, 32'h0);
        check("tbl_data", q[15:0], {8'(prim[i]), gr[i] == 0 ? 4'h2 : 4'hb, 1'b1, 1'(mrx[i]), 2'(gr[i])});
      end
    end
    wb(1'b0, STATUS_OFFSET, 32'h0);
    check("status", q[15:0], {8'(nreg), 8'(lastg)});
    check("host_frames", host_cnt, nrep);
    end_sim();
  end
endmodule : multicast_mode0_forwarding_test
